// File: osi_chk.sv
// assertions on the off-cause, summary and bus handshake ports
`default_nettype none
module osi_chk
#(
   parameter int GRP_W = 16
)(
   input wire logic             clk,
   input wire logic             sys_rst,
   input wire logic             offEvent,
   input wire logic             off_by_internal_regulator_error,
   input wire logic             off_by_sequence_failure,
   input wire logic             off_by_general_input,
   input wire logic             off_by_supply_threshold,
   input wire logic             off_by_overtemperature,
   input wire logic             off_by_software,
   input wire logic             off_by_power_pin,
   input wire logic [GRP_W-1:0] powerStateFlags,
   input wire logic [GRP_W-1:0] thermalFlags,
   input wire logic [GRP_W-1:0] generalInputFlags,
   input wire logic [GRP_W-1:0] powerPinFlags,
   input wire logic [GRP_W-1:0] watchdogFlags,
   input wire logic [GRP_W-1:0] auxConverterFlags,
   input wire logic [GRP_W-1:0] powerPathFlags,
   input wire logic [GRP_W-1:0] rtcFlags,
   input wire logic [GRP_W-1:0] otpFlags,
   input wire logic [GRP_W-1:0] highCurrentFlags,
   input wire logic [GRP_W-1:0] undervoltageFlags,
   input wire logic [15:0]      offCauseRecord,
   input wire logic [15:0]      primaryIrqSummary,
   input wire logic             s_axi_awvalid,
   input wire logic             s_axi_awready,
   input wire logic             s_axi_wvalid,
   input wire logic             s_axi_wready,
   input wire logic             s_axi_bvalid,
   input wire logic             s_axi_arvalid,
   input wire logic             s_axi_arready,
   input wire logic             s_axi_rvalid,
   input wire logic             s_axi_rready,
   input wire logic [31:0]      s_axi_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   wire logic [15:0] recExp = {2'h0, off_by_internal_regulator_error, off_by_sequence_failure,
      off_by_general_input, off_by_supply_threshold, off_by_overtemperature, 2'h0,
      off_by_software, 1'b0, off_by_power_pin, 4'h0};
   wire logic [15:0] sumExp = {|powerStateFlags, |thermalFlags, |generalInputFlags,
      |powerPinFlags, |watchdogFlags, 2'h0, |auxConverterFlags, |powerPathFlags, 1'b0,
      |rtcFlags, |otpFlags, 2'h0, |highCurrentFlags, |undervoltageFlags};
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   property p_rec_load; offEvent |=> offCauseRecord == $past(recExp); endproperty
   property p_rec_hold; !offEvent |=> $stable(offCauseRecord); endproperty
   property p_sum; 1'b1 |=> primaryIrqSummary == $past(sumExp); endproperty
   property p_unused;
      (primaryIrqSummary & 16'h064c) == 16'h0 && (offCauseRecord & 16'hc1af) == 16'h0;
   endproperty
   property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_wr_lat; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
   property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_rec_load: assert property (p_rec_load)
      else $error("record not loaded from causes");
   a_rec_hold: assert property (p_rec_hold)
      else $error("record changed without off event");
   a_sum: assert property (p_sum)
      else $error("summary does not follow group flags");
   a_unused: assert property (p_unused)
      else $error("unused bit set");
   a_rd_lat: assert property (p_rd_lat)
      else $error("read answer late");
   a_r_hold: assert property (p_r_hold)
      else $error("read answer not held");
   a_wr_lat: assert property (p_wr_lat)
      else $error("write answer late");
   a_ar_block: assert property (p_ar_block)
      else $error("read address taken while answer pending");
endmodule
bind osi_off_summary osi_chk #(.GRP_W(GRP_W)) chk_u (.clk, .sys_rst, .offEvent,
   .off_by_internal_regulator_error, .off_by_sequence_failure, .off_by_general_input,
   .off_by_supply_threshold, .off_by_overtemperature, .off_by_software, .off_by_power_pin,
   .powerStateFlags, .thermalFlags, .generalInputFlags, .powerPinFlags, .watchdogFlags,
   .auxConverterFlags, .powerPathFlags, .rtcFlags, .otpFlags, .highCurrentFlags,
   .undervoltageFlags, .offCauseRecord, .primaryIrqSummary, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire

// File: osi_flag_model.sv
// model of the second-level flag groups feeding the summary
`default_nettype none
module osi_flag_model
(
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         setReq,
   input  wire logic         clrReq,
   input  wire logic [3:0]   grp,
   input  wire logic [3:0]   pos,
   output logic [10:0][15:0] flags
);
   timeunit 1ns;
   timeprecision 1ns;
   // set wins over clear, as an event source would
   always_ff @(posedge clk or posedge sys_rst)
      if (sys_rst)
         flags <= '0;
      else if (setReq)
         flags[grp][pos] <= 1'b1;
      else if (clrReq)
         flags[grp][pos] <= 1'b0; // write of one drops the flag
endmodule
`default_nettype wire

// File: osi_off_summary.sv
// off-cause record, interrupt summary and AXI4-Lite register slave
`default_nettype none

module osi_off_summary
   import osi_pkg::*;
#(
   parameter int ADDR_W = 18,
   parameter int GRP_W  = 16
)(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // power state machine: off event with its causes
   input  wire logic              offEvent,
   input  wire logic              off_by_internal_regulator_error,
   input  wire logic              off_by_sequence_failure,
   input  wire logic              off_by_general_input,
   input  wire logic              off_by_supply_threshold,
   input  wire logic              off_by_overtemperature,
   input  wire logic              off_by_software,
   input  wire logic              off_by_power_pin,
   // second-level pending flags per group
   input  wire logic [GRP_W-1:0]  powerStateFlags,
   input  wire logic [GRP_W-1:0]  thermalFlags,
   input  wire logic [GRP_W-1:0]  generalInputFlags,
   input  wire logic [GRP_W-1:0]  powerPinFlags,
   input  wire logic [GRP_W-1:0]  watchdogFlags,
   input  wire logic [GRP_W-1:0]  auxConverterFlags,
   input  wire logic [GRP_W-1:0]  powerPathFlags,
   input  wire logic [GRP_W-1:0]  rtcFlags,
   input  wire logic [GRP_W-1:0]  otpFlags,
   input  wire logic [GRP_W-1:0]  highCurrentFlags,
   input  wire logic [GRP_W-1:0]  undervoltageFlags,
   // visible state
   output logic [15:0]            offCauseRecord,
   output logic [15:0]            primaryIrqSummary,
   output logic                   irq
);

   // elaboration checks: refuse sizes and bit maps the logic cannot serve
   if (ADDR_W < 18 || ADDR_W > 32)
   begin : g_chk_addr
      $error("osi_off_summary: ADDR_W must be 18 to 32");
   end
   if (GRP_W < 1)
   begin : g_chk_grp
      $error("osi_off_summary: GRP_W must be at least 1");
   end
   // status and enable are read back in the low lanes of one word
   if (IRQ_W < 2 || IRQ_W > 16)
   begin : g_chk_irq_w
      $error("osi_off_summary: IRQ_W must be 2 to 16");
   end
   if (IRQ_OFF_BIT >= IRQ_W || IRQ_SUMMARY_BIT >= IRQ_W || IRQ_OFF_BIT == IRQ_SUMMARY_BIT)
   begin : g_chk_irq_map
      $error("osi_off_summary: interrupt bits must be distinct and inside IRQ_W");
   end
   if (OFF_INTREG_BIT > 15 || OFF_SEQ_BIT > 15 || OFF_GPIN_BIT > 15 ||
       OFF_SUPPLY_BIT > 15 || OFF_TEMP_BIT > 15 || OFF_SW_BIT > 15 || OFF_PIN_BIT > 15)
   begin : g_chk_off_map
      $error("osi_off_summary: off-cause bits must lie inside the 16-bit record");
   end
   if (SUM_PSTATE_BIT > 15 || SUM_THERMAL_BIT > 15 || SUM_GPIN_BIT > 15 ||
       SUM_PIN_BIT > 15 || SUM_WDOG_BIT > 15 || SUM_AUX_BIT > 15 ||
       SUM_PPATH_BIT > 15 || SUM_RTC_BIT > 15 || SUM_OTP_BIT > 15 ||
       SUM_HC_BIT > 15 || SUM_UV_BIT > 15)
   begin : g_chk_sum_map
      $error("osi_off_summary: summary bits must lie inside the 16-bit word");
   end
   // the five registers need five distinct word indices
   if (OFF_CAUSE_IDX == SUMMARY_IDX || OFF_CAUSE_IDX == IRQ_STATUS_IDX ||
       OFF_CAUSE_IDX == IRQ_CLEAR_IDX || OFF_CAUSE_IDX == IRQ_ENABLE_IDX ||
       SUMMARY_IDX == IRQ_STATUS_IDX || SUMMARY_IDX == IRQ_CLEAR_IDX ||
       SUMMARY_IDX == IRQ_ENABLE_IDX || IRQ_STATUS_IDX == IRQ_CLEAR_IDX ||
       IRQ_STATUS_IDX == IRQ_ENABLE_IDX || IRQ_CLEAR_IDX == IRQ_ENABLE_IDX)
   begin : g_chk_idx
      $error("osi_off_summary: register indices must differ");
   end

   // index to byte address match, word aligned
   function automatic logic hitReg(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
      hitReg = (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
   endfunction

   // write channel holding
   logic              awHeld;
   logic              wHeld;
   logic [ADDR_W-1:0] awAddr;
   logic [31:0]       wData;
   logic [3:0]        wStrb;
   logic [IRQ_W-1:0]  irqStatus;
   logic [IRQ_W-1:0]  irqEnable;

   wire awFire  = s_axi_awvalid && s_axi_awready;
   wire wFire   = s_axi_wvalid && s_axi_wready;
   wire doWrite = awHeld && wHeld && !s_axi_bvalid;
   wire arFire  = s_axi_arvalid && s_axi_arready;

   assign s_axi_awready = !awHeld && !s_axi_bvalid;
   assign s_axi_wready  = !wHeld && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // write decode; off-cause and summary accept writes without effect
   wire wrOffCause = hitReg(awAddr, OFF_CAUSE_IDX);
   wire wrSummary  = hitReg(awAddr, SUMMARY_IDX);
   wire wrStatus   = hitReg(awAddr, IRQ_STATUS_IDX);
   wire wrClear    = hitReg(awAddr, IRQ_CLEAR_IDX);
   wire wrEnable   = hitReg(awAddr, IRQ_ENABLE_IDX);
   logic [1:0] wrResp;
   always_comb
   begin
      if (wrOffCause || wrSummary || wrStatus)
         wrResp = RESP_OKAY;
      else if (wrClear || wrEnable)
         wrResp = RESP_OKAY;
      else
         wrResp = RESP_SLVERR;
   end

   // off record: every event rewrites the whole word
   logic [15:0] offWord;
   always_comb
   begin
      offWord = 16'h0000;
      offWord[OFF_INTREG_BIT] = off_by_internal_regulator_error;
      offWord[OFF_SEQ_BIT]    = off_by_sequence_failure;
      offWord[OFF_GPIN_BIT]   = off_by_general_input;
      offWord[OFF_SUPPLY_BIT] = off_by_supply_threshold;
      offWord[OFF_TEMP_BIT]   = off_by_overtemperature;
      offWord[OFF_SW_BIT]     = off_by_software;
      offWord[OFF_PIN_BIT]    = off_by_power_pin;
   end
   wire [15:0] next_offCauseRecord = offEvent ? offWord : offCauseRecord;

   // summary: OR of each group's pending flags, cleared upstream
   logic [15:0] next_primaryIrqSummary;
   always_comb
   begin
      next_primaryIrqSummary = 16'h0000;
      next_primaryIrqSummary[SUM_PSTATE_BIT]  = |powerStateFlags;
      next_primaryIrqSummary[SUM_THERMAL_BIT] = |thermalFlags;
      next_primaryIrqSummary[SUM_GPIN_BIT]    = |generalInputFlags;
      next_primaryIrqSummary[SUM_PIN_BIT]     = |powerPinFlags;
      next_primaryIrqSummary[SUM_WDOG_BIT]    = |watchdogFlags;
      next_primaryIrqSummary[SUM_AUX_BIT]     = |auxConverterFlags;
      next_primaryIrqSummary[SUM_PPATH_BIT]   = |powerPathFlags;
      next_primaryIrqSummary[SUM_RTC_BIT]     = |rtcFlags;
      next_primaryIrqSummary[SUM_OTP_BIT]     = |otpFlags;
      next_primaryIrqSummary[SUM_HC_BIT]      = |highCurrentFlags;
      next_primaryIrqSummary[SUM_UV_BIT]      = |undervoltageFlags;
   end

   // interrupt events; set wins over a clear in the same cycle
   logic [IRQ_W-1:0] irqEvent;
   always_comb
   begin
      irqEvent = '0;
      irqEvent[IRQ_OFF_BIT]     = offEvent;
      irqEvent[IRQ_SUMMARY_BIT] = |(next_primaryIrqSummary & ~primaryIrqSummary);
   end
   wire clearHit = doWrite && wrClear && wStrb[0];
   wire [IRQ_W-1:0] clearBits = clearHit ? wData[IRQ_W-1:0] : '0;
   wire [IRQ_W-1:0] next_irqStatus = (irqStatus & ~clearBits) | irqEvent;
   wire [IRQ_W-1:0] next_irqEnable =
      (doWrite && wrEnable && wStrb[0]) ? wData[IRQ_W-1:0] : irqEnable;

   // read decode
   wire rdOffCause = hitReg(s_axi_araddr, OFF_CAUSE_IDX);
   wire rdSummary  = hitReg(s_axi_araddr, SUMMARY_IDX);
   wire rdStatus   = hitReg(s_axi_araddr, IRQ_STATUS_IDX);
   wire rdClear    = hitReg(s_axi_araddr, IRQ_CLEAR_IDX);
   wire rdEnable   = hitReg(s_axi_araddr, IRQ_ENABLE_IDX);
   // upper lanes always read zero
   logic [31:0] rdWord;
   always_comb
   begin
      rdWord = 32'h0000_0000;
      if (rdOffCause)
         rdWord[15:0] = offCauseRecord;
      else if (rdSummary)
         rdWord[15:0] = primaryIrqSummary;
      else if (rdStatus)
         rdWord[IRQ_W-1:0] = irqStatus;
      else if (rdEnable)
         rdWord[IRQ_W-1:0] = irqEnable;
   end

   // clear register reads zero, it only acts on write
   logic [1:0] rdResp;
   always_comb
   begin
      if (rdOffCause || rdSummary || rdStatus)
         rdResp = RESP_OKAY;
      else if (rdClear || rdEnable)
         rdResp = RESP_OKAY;
      else
         rdResp = RESP_SLVERR;
   end

   // record owned by the power state machine; software cannot write it
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         offCauseRecord <= OFF_CAUSE_RESET;
      else
         offCauseRecord <= next_offCauseRecord;
   end

   // summary trails the group flags by one cycle
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         primaryIrqSummary <= SUMMARY_RESET;
      else
         primaryIrqSummary <= next_primaryIrqSummary;
   end

   // sticky status; a clear never hides an event of the same cycle
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         irqStatus <= IRQ_RESET;
      else
         irqStatus <= next_irqStatus;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         irqEnable <= IRQ_RESET;
      else
         irqEnable <= next_irqEnable;
   end

   // output registered from next values so it does not lag the status
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         irq <= 1'b0;
      else
         irq <= |(next_irqStatus & next_irqEnable);
   end

   // write channel: address and data taken in either order
   logic next_awHeld;
   logic next_wHeld;
   always_comb
   begin
      next_awHeld = awHeld;
      next_wHeld  = wHeld;
      if (awFire)
         next_awHeld = 1'b1;
      else if (doWrite)
         next_awHeld = 1'b0;
      if (wFire)
         next_wHeld = 1'b1;
      else if (doWrite)
         next_wHeld = 1'b0;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         awHeld <= 1'b0;
         wHeld  <= 1'b0;
      end
      else
      begin
         awHeld <= next_awHeld;
         wHeld  <= next_wHeld;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         awAddr <= '0;
      else if (awFire)
         awAddr <= s_axi_awaddr;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
      end
      else if (wFire)
      begin
         wData <= s_axi_wdata;
         wStrb <= s_axi_wstrb;
      end
   end

   // write response stands until the master takes it
   logic next_bvalid;
   always_comb
   begin
      next_bvalid = s_axi_bvalid;
      if (doWrite)
         next_bvalid = 1'b1;
      else if (s_axi_bready)
         next_bvalid = 1'b0;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else
      begin
         s_axi_bvalid <= next_bvalid;
         if (doWrite)
            s_axi_bresp <= wrResp;
      end
   end

   // read: one request at a time, answered the cycle after it is taken
   logic next_rvalid;
   always_comb
   begin
      next_rvalid = s_axi_rvalid;
      if (arFire)
         next_rvalid = 1'b1;
      else if (s_axi_rready)
         next_rvalid = 1'b0;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         s_axi_rvalid <= 1'b0;
      else
         s_axi_rvalid <= next_rvalid;
   end

   // data and response change only when a new request is taken
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (arFire)
      begin
         s_axi_rdata <= rdWord;
         s_axi_rresp <= rdResp;
      end
   end

endmodule

`default_nettype wire

// File: osi_pkg.sv
// constants for the off-cause record and interrupt summary block
`default_nettype none

package osi_pkg;

   // register indices; byte address is four times the index
   localparam logic [15:0] OFF_CAUSE_IDX  = 16'h400f;
   localparam logic [15:0] SUMMARY_IDX    = 16'h4010;
   localparam logic [15:0] IRQ_STATUS_IDX = 16'h4020;
   localparam logic [15:0] IRQ_CLEAR_IDX  = 16'h4021;
   localparam logic [15:0] IRQ_ENABLE_IDX = 16'h4022;

   localparam logic [15:0] OFF_CAUSE_RESET = 16'h0000;
   localparam logic [15:0] SUMMARY_RESET   = 16'h0000;
   localparam logic [1:0]  IRQ_RESET       = 2'h0;

   // off-cause bit positions
   localparam int OFF_INTREG_BIT   = 13;
   localparam int OFF_SEQ_BIT      = 12;
   localparam int OFF_GPIN_BIT     = 11;
   localparam int OFF_SUPPLY_BIT   = 10;
   localparam int OFF_TEMP_BIT     = 9;
   localparam int OFF_SW_BIT       = 6;
   localparam int OFF_PIN_BIT      = 4;

   // summary bit positions
   localparam int SUM_PSTATE_BIT   = 15;
   localparam int SUM_THERMAL_BIT  = 14;
   localparam int SUM_GPIN_BIT     = 13;
   localparam int SUM_PIN_BIT      = 12;
   localparam int SUM_WDOG_BIT     = 11;
   localparam int SUM_AUX_BIT      = 8;
   localparam int SUM_PPATH_BIT    = 7;
   localparam int SUM_RTC_BIT      = 5;
   localparam int SUM_OTP_BIT      = 4;
   localparam int SUM_HC_BIT       = 1;
   localparam int SUM_UV_BIT       = 0;

   // interrupt status, clear and enable layout
   localparam int IRQ_W            = 2;
   localparam int IRQ_OFF_BIT      = 0;
   localparam int IRQ_SUMMARY_BIT  = 1;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// File: tb_top.sv
// self-checking bench for the off-cause record and interrupt summary
`default_nettype none
module tb_top import osi_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, sys_rst = 1, offEvent = 0, setReq = 0, clrReq = 0, irq;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
   logic [6:0] cause = '0;
   logic [3:0] grp = '0, pos = '0;
   logic [10:0][15:0] flags;
   logic [15:0] offCauseRecord, primaryIrqSummary;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   int miscompares = 0, cmpCount = 0;
   int cpos[7] = '{4, 6, 9, 10, 11, 12, 13};
   int spos[11] = '{15, 14, 13, 12, 11, 8, 7, 5, 4, 1, 0};
   localparam logic [17:0] A_REC = {OFF_CAUSE_IDX, 2'h0}, A_SUM = {SUMMARY_IDX, 2'h0};
   localparam logic [17:0] A_STS = {IRQ_STATUS_IDX, 2'h0}, A_CLR = {IRQ_CLEAR_IDX, 2'h0};
   localparam logic [17:0] A_EN = {IRQ_ENABLE_IDX, 2'h0};
   osi_flag_model model_u (.clk, .sys_rst, .setReq, .clrReq, .grp, .pos, .flags);
   osi_off_summary dut_u (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .offEvent, .off_by_internal_regulator_error(cause[6]), .off_by_sequence_failure(cause[5]),
      .off_by_general_input(cause[4]), .off_by_supply_threshold(cause[3]),
      .off_by_overtemperature(cause[2]), .off_by_software(cause[1]), .off_by_power_pin(cause[0]),
      .powerStateFlags(flags[0]), .thermalFlags(flags[1]), .generalInputFlags(flags[2]),
      .powerPinFlags(flags[3]), .watchdogFlags(flags[4]), .auxConverterFlags(flags[5]),
      .powerPathFlags(flags[6]), .rtcFlags(flags[7]), .otpFlags(flags[8]),
      .highCurrentFlags(flags[9]), .undervoltageFlags(flags[10]), .offCauseRecord,
      .primaryIrqSummary, .irq);
   initial
      forever #10 clk = ~clk;
   task automatic stop_test();
      $display("miscompares %0d cmpCount %0d", miscompares, cmpCount);
      if (miscompares == 0 && cmpCount > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [17:0] a, input logic [31:0] v);
      int n;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 64 && !(s_axi_bvalid && s_axi_bready); n++)
      begin
         @(posedge clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 64)
      begin
         miscompares++;
         stop_test();
      end
   endtask
   task automatic rd(input logic [17:0] a);
      int n;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 64 && !(s_axi_rvalid && s_axi_rready); n++)
      begin
         @(posedge clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 64)
      begin
         miscompares++;
         stop_test();
      end
   endtask
   // causes flip after the pulse: they must be ignored without an event
   task automatic ev(input logic [6:0] c);
      @(posedge clk);
      cause <= c;
      offEvent <= 1'b1;
      @(posedge clk);
      offEvent <= 1'b0;
      cause <= ~c;
   endtask
   task automatic fl(input logic s, input int g, input int p);
      @(posedge clk);
      setReq <= s;
      clrReq <= !s;
      grp <= g[3:0];
      pos <= p[3:0];
      @(posedge clk);
      setReq <= 1'b0;
      clrReq <= 1'b0;
   endtask
   initial
   begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      rd(A_REC);
      chk(d, 32'h0);
      rd(A_SUM);
      chk(d, 32'h0);
      ev(7'h7f);
      rd(A_REC);
      chk(d, 32'h3e50);
      for (int i = 0; i < 7; i++)
      begin
         ev(7'(1 << i));
         rd(A_REC);
         chk(d, 32'h1 << cpos[i]);
      end
      for (int g = 0; g < 11; g++)
      begin
         fl(1'b1, g, g);
         rd(A_SUM);
         chk(d, 32'h1 << spos[g]);
         fl(1'b0, g, g);
         rd(A_SUM);
         chk(d, 32'h0);
      end
      wr(A_SUM, 32'hffff);
      chk(32'(r), 32'(RESP_OKAY));
      rd(A_SUM);
      chk(d, 32'h0);
      wr(A_REC, 32'hffff);
      rd(A_REC);
      chk(d, 32'h1 << cpos[6]);
      rd(18'h00100);
      chk(32'(r), 32'(RESP_SLVERR));
      chk(d, 32'h0);
      wr(A_CLR, 32'h3);
      wr(A_EN, 32'h1);
      ev(7'h01);
      rd(A_STS);
      chk(d, 32'h1);
      chk(32'(irq), 32'h1);
      wr(A_CLR, 32'h1);
      rd(A_STS);
      chk(d, 32'h0);
      chk(32'(irq), 32'h0);
      // event masked, summary rise enabled
      wr(A_EN, 32'h2);
      ev(7'h01);
      rd(A_STS);
      chk(d, 32'h1);
      chk(32'(irq), 32'h0);
      fl(1'b1, 0, 3);
      rd(A_STS);
      chk(d, 32'h3);
      chk(32'(irq), 32'h1);
      rd(A_EN);
      chk(d, 32'h2);
      stop_test();
   end
endmodule
`default_nettype wire
